/* shared/adcrp_if.sv */
`timescale 1ns/100ps
interface adcrp_if;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic high_byte_select;
  logic conv_clk;
  logic [7:0] host_d;
  logic host_oe;
  logic [7:0] dev_d;
  logic dev_oe;
  logic done_n;
  wire [7:0] bus_d = dev_oe ? dev_d : (host_oe ? host_d : 8'h00);
  modport device (input cs_n, wr_n, rd_n, high_byte_select, conv_clk, bus_d,
    output dev_d, dev_oe, done_n);
  modport host (output cs_n, wr_n, rd_n, high_byte_select, conv_clk, host_d, host_oe,
    input bus_d, done_n);
endinterface

/* shared/adcrp_pkg.sv */
package adcrp_pkg;
  // control byte field positions
  localparam int unsigned CTL_W = 8;
  localparam int unsigned PM_HI_BIT = 7;
  localparam int unsigned PM_LO_BIT = 6;
  localparam int unsigned ACQ_BIT = 5;
  localparam int unsigned SGL_BIT = 4;
  localparam int unsigned UNI_BIT = 3;
  // result layout
  localparam int unsigned RES_W = 12;
  localparam int unsigned LO_W = 8;
  localparam int unsigned HI_W = 4;
  localparam int unsigned MSB_BIT = 11;
  // power-mode codes {hi,lo}
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_INTCLK = 2'h2;
  localparam logic [1:0] PM_EXTCLK = 2'h3;
  localparam logic [1:0] PM_SHUTDOWN = 2'h0;
  // sequence budget in conversion-clock cycles
  localparam int unsigned WR_CYC = 1;
  localparam int unsigned ACQ_CYC = 3;
  localparam int unsigned CONV_CYC = 13;
  localparam int unsigned RD_CYC = 2;
  localparam int unsigned SEQ_CYC = WR_CYC + ACQ_CYC + CONV_CYC + RD_CYC;
  localparam int unsigned PIPE_CYC = WR_CYC + ACQ_CYC + CONV_CYC - 1;
  localparam logic [4:0] ACQ_LAST = 5'(ACQ_CYC - 1);
  localparam logic [4:0] CONV_LAST = 5'(CONV_CYC - 1);
  // host-side times
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned POR_US = 10;
  localparam int unsigned WAKE_INT_US = 500;
  localparam int unsigned WAKE_EXT_US = 50;
  localparam int unsigned POR_CYC = POR_US * CLK_MHZ;
  localparam int unsigned WAKE_INT_CYC = WAKE_INT_US * CLK_MHZ;
  localparam int unsigned WAKE_EXT_CYC = WAKE_EXT_US * CLK_MHZ;
  // conversion clock divider: 250 MHz / 36 stays below 7.6 MHz
  localparam logic [4:0] CCLK_HALF = 5'h11;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  localparam logic [CTL_W-1:0] CTL_RST = 8'hc8;
endpackage

/* verification/adcrp_assertions.sv */
`timescale 1ns/100ps
module adcrp_assertions #(
  parameter int unsigned POR_WAIT = 50
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic host_oe,
  input wire logic [7:0] dev_d,
  input wire logic dev_oe,
  input wire logic done_n
);
  logic [15:0] por_reg;
  logic [15:0] wr_age_reg;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // cycles since reset and since the last write strobe, both saturating
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_reg <= 16'h0;
      wr_age_reg <= 16'hffff;
    end else begin
      por_reg <= (por_reg == 16'hffff) ? por_reg : por_reg + 16'h1;
      wr_age_reg <= (!wr_n) ? 16'h0 : ((wr_age_reg == 16'hffff) ? wr_age_reg : wr_age_reg + 16'h1);
    end
  end
  chk_por_quiet: assert property (por_reg < POR_WAIT |-> wr_n)
    else $error("write strobe during reset interval");
  chk_done_rst: assert property ($rose(nrst_i) |-> done_n)
    else $error("done low after reset");
  chk_conv_span: assert property ($fell(done_n) |-> wr_age_reg >= 16'h100)
    else $error("conversion ended too soon after write");
  chk_done_stands: assert property ((!done_n && rd_n && wr_n) [*4] |=> !done_n)
    else $error("done released without read or write");
  chk_bus_idle: assert property ((cs_n || rd_n) [*4] |-> !dev_oe)
    else $error("device drives bus while not selected for read");
  chk_no_clash: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the bus");
  chk_hi_fill: assert property ((dev_oe && high_byte_select) [*6] |->
    (dev_d[7:4] == 4'h0 || dev_d[7:4] == {4{dev_d[3]}}))
    else $error("upper lines neither zero nor sign copy");
  chk_res_hold: assert property ((dev_oe && $stable(high_byte_select)) [*6] |-> $stable(dev_d))
    else $error("read data moved during a read");
  chk_wr_drive: assert property (!wr_n |-> !cs_n && host_oe)
    else $error("write strobe without select or data");
  // main scenarios reached
  cov_done: cover property ($fell(done_n));
  cov_hi_read: cover property (dev_oe && high_byte_select);
  cov_write: cover property ($rose(wr_n) && !cs_n);
endmodule // adcrp_assertions

/* verification/tb.sv */
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic start_i = 1'h0;
  logic [7:0] ctl_i = 8'h0;
  logic [11:0] sample_i = 12'h0;
  logic [1:0] power_state_o;
  logic int_clk_mode_o, busy_o, ready_o, result_valid_o, exp_int;
  logic [7:0] ctl_o, lo_seen, hi_seen;
  logic [11:0] result_o;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  adcrp_if bus ();
  always #2 sys_clk_i = ~sys_clk_i;
  adcrp_device adcrp_device_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(1'h1),
    .link(bus.device), .sample_i(sample_i), .power_state_o(power_state_o),
    .int_clk_mode_o(int_clk_mode_o), .busy_o(busy_o), .ctl_o(ctl_o));
  adcrp_host #(.POR_WAIT(50)) adcrp_host_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .clk_en_i(1'h1), .link(bus.host), .start_i(start_i), .ctl_i(ctl_i), .ready_o(ready_o),
    .result_o(result_o), .result_valid_o(result_valid_o));
  adcrp_assertions #(.POR_WAIT(50)) adcrp_assertions_i (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
    .high_byte_select(bus.high_byte_select), .host_oe(bus.host_oe), .dev_d(bus.dev_d),
    .dev_oe(bus.dev_oe), .done_n(bus.done_n));
  // capture read bytes off the wire and cut a hang short
  always @(posedge sys_clk_i) begin
    cycles++;
    if (bus.dev_oe === 1'h1 && bus.high_byte_select === 1'h1) hi_seen <= bus.bus_d;
    if (bus.dev_oe === 1'h1 && bus.high_byte_select === 1'h0) lo_seen <= bus.bus_d;
    if (cycles == 40000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic fail(input string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic chk_res(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) fail("result word differs");
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) fail("bus byte differs");
  endtask
  task automatic chk_mode(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) fail("power or clock mode differs");
  endtask
  function automatic logic [7:0] exp_hi(input logic [11:0] s, input logic uni);
    return {uni ? 4'h0 : {4{s[11]}}, s[11:8]};
  endfunction
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk_i);
    while (ready_o !== 1'h1 && n < 5000) begin
      @(posedge sys_clk_i);
      n++;
    end
    #1;
  endtask
  // one host request; checks result and both bus bytes when a conversion is expected
  task automatic run(input logic [7:0] ctl, input logic [11:0] smp, input logic conv);
    int n;
    n = 0;
    sample_i = smp;
    ctl_i = ctl;
    start_i = 1'h1;
    @(posedge sys_clk_i);
    #1 start_i = 1'h0;
    if (conv) begin
      while (result_valid_o !== 1'h1 && n < 3000) begin
        @(posedge sys_clk_i);
        #1;
        n++;
      end
      chk_res(result_o, smp);
      chk_byte(lo_seen, smp[7:0]);
      chk_byte(hi_seen, exp_hi(smp, ctl[3]));
    end
    wait_ready();
  endtask
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // reset, corner and random conversions, then low-power entry and wake
  initial begin
    logic [11:0] corner [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
    logic [7:0] ctl;
    logic [11:0] smp;
    void'($urandom(98));
    repeat (6) @(posedge sys_clk_i);
    #1 nrst_i = 1'h1;
    chk_mode({power_state_o, int_clk_mode_o}, {adcrp_pkg::PM_EXTCLK, 1'h0});
    chk_mode({2'h0, bus.done_n}, 3'h1);
    wait_ready();
    for (int i = 0; i < 16; i++) begin
      smp = (i < 4) ? corner[i] : 12'($urandom);
      ctl = {1'h1, 1'(i), 2'h1, 1'(i >> 1), 3'($urandom)};
      run(ctl, smp, 1'h1);
      exp_int = ~ctl[6];
      chk_mode({power_state_o, int_clk_mode_o}, {ctl[7:6], exp_int});
    end
    for (int k = 0; k < 2; k++) begin
      ctl = {k ? adcrp_pkg::PM_STANDBY : adcrp_pkg::PM_SHUTDOWN, 6'h08};
      run(ctl, 12'h0, 1'h0);
      chk_mode({power_state_o, k ? int_clk_mode_o : exp_int}, {ctl[7:6], exp_int});
      run(8'hc8, 12'($urandom), 1'h1);
      exp_int = 1'h0;
      chk_mode({power_state_o, int_clk_mode_o}, {adcrp_pkg::PM_EXTCLK, 1'h0});
    end
    final_report();
  end
endmodule // tb

/* verilog/adcrp_device.sv */
`timescale 1ns/100ps
module adcrp_device (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  adcrp_if.device link,
  input wire logic [11:0] sample_i,
  output logic [1:0] power_state_o,
  output logic int_clk_mode_o,
  output logic busy_o,
  output logic [7:0] ctl_o
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACQ = 2'b01, ST_CONV = 2'b11} adcrp_e;
  adcrp_e st_reg, st_next;
  logic [2:0] cs_s1, wr_s1, rd_s1, cs_s2, wr_s2, rd_s2;
  logic wr_q_reg, cclk_q_reg, hb_s1, hb_s2, cclk_s1, cclk_s2;
  logic [7:0] d_s1, d_s2;
  logic [7:0] ctl_reg;
  logic int_clk_reg, done_n_reg, pend_sd_reg;
  logic [1:0] pwr_reg;
  logic [4:0] cnt_reg, icnt_reg;
  logic [11:0] res_reg, smp_reg;
  logic [7:0] dout_reg;
  // synchronise all pins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_s1 <= 3'h7; cs_s2 <= 3'h7;
      wr_s1 <= 3'h7; wr_s2 <= 3'h7;
      rd_s1 <= 3'h7; rd_s2 <= 3'h7;
      hb_s1 <= 1'b0; hb_s2 <= 1'b0;
      cclk_s1 <= 1'b0; cclk_s2 <= 1'b0;
      d_s1 <= 8'h00; d_s2 <= 8'h00;
    end else if (clk_en_i) begin
      cs_s1 <= {2'h3, link.cs_n}; cs_s2 <= cs_s1;
      wr_s1 <= {2'h3, link.wr_n}; wr_s2 <= wr_s1;
      rd_s1 <= {2'h3, link.rd_n}; rd_s2 <= rd_s1;
      hb_s1 <= link.high_byte_select; hb_s2 <= hb_s1;
      cclk_s1 <= link.conv_clk; cclk_s2 <= cclk_s1;
      d_s1 <= link.bus_d; d_s2 <= d_s1;
    end
  end
  wire cs_act = ~cs_s2[0];
  wire wr_low = cs_act & ~wr_s2[0];
  wire rd_act = cs_act & ~rd_s2[0];
  wire wr_rise = wr_q_reg & ~wr_low;
  wire cclk_rise = cs_act & cclk_s2 & ~cclk_q_reg;
  wire [1:0] pm_w = {d_s2[adcrp_pkg::PM_HI_BIT], d_s2[adcrp_pkg::PM_LO_BIT]};
  wire awake = (pwr_reg == adcrp_pkg::PM_INTCLK) | (pwr_reg == adcrp_pkg::PM_EXTCLK);
  wire int_tick = icnt_reg == adcrp_pkg::CCLK_HALF;
  wire tick = int_clk_reg ? int_tick : cclk_rise;
  wire conv_end = (st_reg == ST_CONV) & tick & (cnt_reg == adcrp_pkg::CONV_LAST);
  wire uni = ctl_reg[adcrp_pkg::UNI_BIT];
  // sign copy in bipolar, zero fill in unipolar
  wire [3:0] hi_fill = uni ? 4'h0 : {4{res_reg[adcrp_pkg::MSB_BIT]}};
  wire [7:0] rd_mux = hb_s2 ? {hi_fill, res_reg[11:8]} : res_reg[7:0];
  // sequencer next state; writes taken while asleep too
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: if (wr_rise) st_next = ST_ACQ;
      ST_ACQ: if (tick && cnt_reg == adcrp_pkg::ACQ_LAST) st_next = ST_CONV;
      ST_CONV: if (conv_end) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    if (wr_rise && st_reg != ST_CONV) st_next = ST_ACQ;
  end
  // sequencer and control state
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= ST_IDLE;
      wr_q_reg <= 1'b0; cclk_q_reg <= 1'b0;
      ctl_reg <= adcrp_pkg::CTL_RST;
      int_clk_reg <= 1'b0;
      pwr_reg <= adcrp_pkg::PM_EXTCLK;
      pend_sd_reg <= 1'b0;
      cnt_reg <= 5'h00; icnt_reg <= 5'h00;
    end else if (clk_en_i) begin
      wr_q_reg <= wr_low;
      cclk_q_reg <= cclk_s2;
      icnt_reg <= int_tick ? 5'h00 : icnt_reg + 5'h01;
      if (st_next != st_reg) cnt_reg <= 5'h00;
      else if (tick && st_reg != ST_IDLE) cnt_reg <= cnt_reg + 5'h01;
      st_reg <= st_next;
      if (wr_rise && st_reg != ST_CONV) begin
        ctl_reg <= d_s2;
        if (pm_w == adcrp_pkg::PM_STANDBY) pwr_reg <= adcrp_pkg::PM_STANDBY;
        else if (pm_w == adcrp_pkg::PM_SHUTDOWN) pend_sd_reg <= 1'b1;
        else begin
          pwr_reg <= pm_w;
          int_clk_reg <= pm_w == adcrp_pkg::PM_INTCLK;
        end
      end else if (wr_rise && !awake) begin
        pwr_reg <= int_clk_reg ? adcrp_pkg::PM_INTCLK : adcrp_pkg::PM_EXTCLK;
      end
      if (pend_sd_reg && st_reg == ST_IDLE) begin
        pwr_reg <= adcrp_pkg::PM_SHUTDOWN;
        pend_sd_reg <= 1'b0;
      end
    end
  end
  // sample capture, result and done flag
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp_reg <= adcrp_pkg::RES_RST;
      res_reg <= adcrp_pkg::RES_RST;
      done_n_reg <= 1'b1;
      dout_reg <= 8'h00;
    end else if (clk_en_i) begin
      if (st_reg == ST_ACQ && st_next == ST_CONV) smp_reg <= sample_i;
      if (conv_end) begin
        res_reg <= smp_reg;
        done_n_reg <= 1'b0;
      end else if (rd_act || wr_rise) begin
        done_n_reg <= 1'b1;
      end
      dout_reg <= rd_mux;
    end
  end
  assign link.dev_d = dout_reg;
  assign link.dev_oe = rd_act;
  assign link.done_n = done_n_reg;
  assign power_state_o = pwr_reg;
  assign int_clk_mode_o = int_clk_reg;
  assign busy_o = st_reg != ST_IDLE;
  assign ctl_o = ctl_reg;
endmodule // adcrp_device

/* verilog/adcrp_host.sv */
`timescale 1ns/100ps
module adcrp_host #(
  parameter int unsigned POR_WAIT = adcrp_pkg::POR_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  adcrp_if.host link,
  input wire logic start_i,
  input wire logic [7:0] ctl_i,
  output logic ready_o,
  output logic [11:0] result_o,
  output logic result_valid_o
);
  typedef enum logic [2:0] {H_POR = 3'b000, H_IDLE = 3'b001, H_WR = 3'b011,
    H_WAIT = 3'b010, H_RLO = 3'b110, H_RHI = 3'b111} adcrp_host_e;
  adcrp_host_e st_reg;
  logic [31:0] cnt_reg;
  logic [7:0] ctl_reg, lo_reg;
  logic [11:0] res_reg;
  logic vld_reg, cclk_reg, done_s1, done_s2;
  logic [4:0] div_reg;
  // done pin synchroniser
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_s1 <= 1'b1; done_s2 <= 1'b1;
    end else if (clk_en_i) begin
      done_s1 <= link.done_n; done_s2 <= done_s1;
    end
  end
  // conversion clock divider
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= 5'h00; cclk_reg <= 1'b0;
    end else if (clk_en_i) begin
      div_reg <= (div_reg == adcrp_pkg::CCLK_HALF) ? 5'h00 : div_reg + 5'h01;
      if (div_reg == adcrp_pkg::CCLK_HALF) cclk_reg <= ~cclk_reg;
    end
  end
  // write, wait for done, read low byte then upper nibble
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= H_POR; cnt_reg <= 32'h0;
      ctl_reg <= 8'h00; lo_reg <= 8'h00;
      res_reg <= adcrp_pkg::RES_RST; vld_reg <= 1'b0;
    end else if (clk_en_i) begin
      vld_reg <= 1'b0;
      cnt_reg <= cnt_reg + 32'h1;
      unique case (st_reg)
        H_POR: if (cnt_reg >= POR_WAIT) st_reg <= H_IDLE;
        H_IDLE: if (start_i) begin
          ctl_reg <= ctl_i; st_reg <= H_WR; cnt_reg <= 32'h0;
        end
        H_WR: if (cnt_reg == 32'h7) st_reg <= H_WAIT;
        H_WAIT: if (!done_s2) begin
          st_reg <= H_RLO; cnt_reg <= 32'h0;
        end else if (ctl_reg[adcrp_pkg::PM_HI_BIT:adcrp_pkg::PM_LO_BIT] !=
                     adcrp_pkg::PM_EXTCLK && ctl_reg[adcrp_pkg::PM_HI_BIT:adcrp_pkg::PM_LO_BIT]
                     != adcrp_pkg::PM_INTCLK && cnt_reg == 32'h400) begin
          st_reg <= H_IDLE; // dummy conversion into low power
        end
        H_RLO: if (cnt_reg == 32'h7) begin
          lo_reg <= link.bus_d; st_reg <= H_RHI; cnt_reg <= 32'h0;
        end
        H_RHI: if (cnt_reg == 32'h7) begin
          res_reg <= {link.bus_d[3:0], lo_reg}; vld_reg <= 1'b1; st_reg <= H_IDLE;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
  // select stays low while waiting so the device keeps taking conversion-clock edges
  assign link.cs_n = !(st_reg == H_WR || st_reg == H_WAIT || st_reg == H_RLO ||
    st_reg == H_RHI);
  assign link.wr_n = !(st_reg == H_WR && cnt_reg < 32'h4);
  assign link.rd_n = !(st_reg == H_RLO || st_reg == H_RHI);
  assign link.high_byte_select = st_reg == H_RHI;
  assign link.conv_clk = cclk_reg;
  assign link.host_d = ctl_reg;
  assign link.host_oe = st_reg == H_WR;
  assign ready_o = st_reg == H_IDLE;
  assign result_o = res_reg;
  assign result_valid_o = vld_reg;
endmodule // adcrp_host
